// ===== ugie_axil_slave.sv
// axi4-lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
module ugie_axil_slave #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register strobes
  output logic reg_wr_en,
  output logic [5:0] reg_wr_idx,
  output logic [7:0] reg_wr_data,
  output logic reg_wr_lane0,
  input wire logic reg_wr_err,
  output logic reg_rd_en,
  output logic [5:0] reg_rd_idx,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_err
);

  typedef struct packed {
    logic aw_held;
    logic [5:0] aw_idx;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } ugie_slave_t;

  ugie_slave_t s_reg;
  ugie_slave_t s_next;

  // a new write is held off while its response is still pending
  assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rdata = {24'h00_0000, s_reg.rdata};

  assign reg_wr_en = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
  assign reg_wr_idx = s_reg.aw_idx;
  assign reg_wr_data = s_reg.w_data;
  assign reg_wr_lane0 = s_reg.w_lane0;
  assign reg_rd_en = s_axi_arvalid && s_axi_arready;
  assign reg_rd_idx = s_axi_araddr[7:2];

  always_comb
  begin
    s_next = s_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_next.aw_held = 1'b1;
      s_next.aw_idx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata[7:0];
      s_next.w_lane0 = s_axi_wstrb[0];
    end
    if (reg_wr_en)
    begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = reg_wr_err ? ugie_pkg::RESP_SLVERR : ugie_pkg::RESP_OKAY;
    end
    else if (s_reg.bvalid && s_axi_bready)
    begin
      s_next.bvalid = 1'b0;
    end
    if (reg_rd_en)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = reg_rd_data;
      s_next.rresp = reg_rd_err ? ugie_pkg::RESP_SLVERR : ugie_pkg::RESP_OKAY;
    end
    else if (s_reg.rvalid && s_axi_rready)
    begin
      s_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule : ugie_axil_slave

// ===== ugie_bus_peer.sv
// usb bus peer model that turns bench commands into one-cycle event pulses
`timescale 1ns/1ps
module ugie_bus_peer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // command: 0 sof, 1 bus reset, 2 resume, 3 suspend, 4 attach, 5 detach, 6 babble
  input wire logic [6:0] cmd,
  // event pulses toward the block
  output logic sof_event,
  output logic bus_reset_event,
  output logic resume_event,
  output logic suspend_event,
  output logic peer_attach_event,
  output logic peer_detach_event,
  output logic babble_event
);
  logic [6:0] pulse_reg;
  // the system clock is never gated here, so the resume status bit stays usable
  always_ff @(posedge aclk)
  begin
    pulse_reg <= aresetn ? cmd : 7'h00;
  end
  assign {babble_event, peer_detach_event, peer_attach_event, suspend_event, resume_event,
    bus_reset_event, sof_event} = pulse_reg;
endmodule : ugie_bus_peer

// ===== ugie_general_irq.sv
// general event status, enable and interrupt logic with its register port
//
// Overview of operation
// - device status: 8 bits, read only, index 0x0a, resets zero, bits 7:4 zero
// - device mode: start of frame sets status bit 3
// - device mode: detected bus reset sets status bit 2
// - bit 1 set by resume signaling seen while the controller is suspended
// - device mode: detected suspend signaling sets status bit 0
// - enable register at index 0x0b, one bit per status interrupt
// - enable register reads 0x06 after reset
// - host mode: enable bit 5 gates the detach event, resets zero
// - host mode: enable bit 4 gates the attach event, resets zero
// - host mode: enable bit 3 gates start of frame, resets zero
// - host mode: enable bit 2 gates babble, resets one
// - host mode: enable bit 1 gates resume; bits 7:6 and 0 read zero
// - any status read clears every bit active at that read that is not set again in the same cycle
// - host mode: peer detach sets status bit 5
// - host mode: peer attach sets status bit 4
// - host mode: babble sets bit 2, only after the first frame start sent
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ugie_general_irq #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // one-cycle event pulses from the bus logic
  input wire logic sof_event,
  input wire logic bus_reset_event,
  input wire logic resume_event,
  input wire logic suspend_event,
  input wire logic peer_attach_event,
  input wire logic peer_detach_event,
  input wire logic babble_event,
  // interrupt to the interrupt controller and mode indication
  output logic irq,
  output logic host_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // register port

  logic reg_wr_en;
  logic [5:0] reg_wr_idx;
  logic [7:0] reg_wr_data;
  logic reg_wr_lane0;
  logic reg_wr_err;
  logic reg_rd_en;
  logic [5:0] reg_rd_idx;
  logic [7:0] reg_rd_data;
  logic reg_rd_err;

  ugie_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_wr_en(reg_wr_en),
    .reg_wr_idx(reg_wr_idx),
    .reg_wr_data(reg_wr_data),
    .reg_wr_lane0(reg_wr_lane0),
    .reg_wr_err(reg_wr_err),
    .reg_rd_en(reg_rd_en),
    .reg_rd_idx(reg_rd_idx),
    .reg_rd_data(reg_rd_data),
    .reg_rd_err(reg_rd_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  ugie_pkg::ugie_core_t c_reg;
  ugie_pkg::ugie_core_t c_next;

  logic wr_status;
  logic wr_enable;
  logic wr_ctrl;
  logic rd_status;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [7:0] stat_mask;
  logic [7:0] en_mask;

  assign wr_status = reg_wr_en && (reg_wr_idx == ugie_pkg::IDX_STATUS);
  assign wr_enable = reg_wr_en && (reg_wr_idx == ugie_pkg::IDX_ENABLE);
  assign wr_ctrl = reg_wr_en && (reg_wr_idx == ugie_pkg::IDX_CTRL);
  assign rd_status = reg_rd_en && (reg_rd_idx == ugie_pkg::IDX_STATUS);

  // status is read only, so a write to it is refused like an unmapped one
  assign reg_wr_err = reg_wr_en && !wr_enable && !wr_ctrl;

  always_comb
  begin
    reg_rd_err = 1'b0;
    unique case (reg_rd_idx)
      ugie_pkg::IDX_STATUS: reg_rd_data = c_reg.status;
      ugie_pkg::IDX_ENABLE: reg_rd_data = c_reg.enable;
      ugie_pkg::IDX_CTRL: reg_rd_data = {5'h00, c_reg.sof_sent, c_reg.suspended,
                                         c_reg.host_mode};
      default:
      begin
        reg_rd_data = 8'h00;
        reg_rd_err = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // event capture and masking

  always_comb
  begin
    c_next = c_reg;
    set_bits = 8'h00;
    if (wr_ctrl && reg_wr_lane0)
    begin
      c_next.host_mode = reg_wr_data[ugie_pkg::BIT_HOST_MODE];
    end
    // a role change restarts suspend and frame tracking for the new role
    if (c_next.host_mode != c_reg.host_mode)
    begin
      c_next.suspended = 1'b0;
      c_next.sof_sent = 1'b0;
    end
    else
    begin
      if (suspend_event)
      begin
        c_next.suspended = 1'b1;
      end
      if (resume_event || bus_reset_event)
      begin
        c_next.suspended = 1'b0;
      end
      if (c_reg.host_mode && sof_event)
      begin
        c_next.sof_sent = 1'b1;
      end
      if (c_reg.host_mode && bus_reset_event)
      begin
        c_next.sof_sent = 1'b0;
      end
    end
    set_bits[ugie_pkg::BIT_SOF] = sof_event;
    set_bits[ugie_pkg::BIT_RESUME] = resume_event && c_reg.suspended;
    if (c_reg.host_mode)
    begin
      set_bits[ugie_pkg::BIT_DETACH] = peer_detach_event;
      set_bits[ugie_pkg::BIT_ATTACH] = peer_attach_event;
      // babble before any frame start went out is not reported
      set_bits[ugie_pkg::BIT_BABBLE] = babble_event && c_reg.sof_sent;
    end
    else
    begin
      set_bits[ugie_pkg::BIT_RESET] = bus_reset_event;
      set_bits[ugie_pkg::BIT_SUSPEND] = suspend_event;
    end
    stat_mask = c_next.host_mode ? ugie_pkg::STATUS_MASK_HOST : ugie_pkg::STATUS_MASK_DEV;
    en_mask = c_next.host_mode ? ugie_pkg::ENABLE_MASK_HOST : ugie_pkg::ENABLE_MASK_DEV;
    // clear only what the read returned; new sets win over the clear
    clr_bits = rd_status ? c_reg.status : 8'h00;
    c_next.status = ((c_reg.status & ~clr_bits) | set_bits) & stat_mask;
    if (wr_enable && reg_wr_lane0)
    begin
      c_next.enable = reg_wr_data;
    end
    c_next.enable = c_next.enable & en_mask;
    // registered so that irq equals the or of the current status bits masked by enable
    c_next.irq = |(c_next.status & c_next.enable);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      c_reg.status <= ugie_pkg::STATUS_RESET;
      c_reg.enable <= ugie_pkg::ENABLE_RESET;
      c_reg.host_mode <= ugie_pkg::HOST_MODE_RESET;
      c_reg.suspended <= 1'b0;
      c_reg.sof_sent <= 1'b0;
      c_reg.irq <= 1'b0;
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  assign irq = c_reg.irq;
  assign host_mode = c_reg.host_mode;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic mode_still;
  logic [7:0] st;
  logic [7:0] en;
  assign mode_still = !wr_ctrl;
  assign st = c_reg.status;
  assign en = c_reg.enable;

  a_status_reserved_zero: assert property (
    (c_reg.host_mode ? (st & ~ugie_pkg::STATUS_MASK_HOST) : (st & ~ugie_pkg::STATUS_MASK_DEV))
    == 8'h00)
    else $error("reserved status bits are set");

  a_sof_sets_bit: assert property (
    sof_event |=> st[3])
    else $error("start of frame did not set bit 3");

  a_reset_sets_bit: assert property (
    !c_reg.host_mode && mode_still && bus_reset_event |=> st[2])
    else $error("bus reset did not set bit 2");

  a_resume_needs_suspend: assert property (
    $rose(st[1]) |-> $past(resume_event && c_reg.suspended))
    else $error("resume bit set without resume while suspended");

  a_resume_sets_bit: assert property (
    resume_event && c_reg.suspended && mode_still |=> st[1])
    else $error("resume while suspended did not set bit 1");

  a_suspend_sets_bit: assert property (
    !c_reg.host_mode && mode_still && suspend_event |=> st[0])
    else $error("suspend did not set bit 0");

  a_enable_write_lands: assert property (
    wr_enable && reg_wr_lane0 && mode_still |=>
    en == ($past(reg_wr_data) & (c_reg.host_mode ? ugie_pkg::ENABLE_MASK_HOST :
                                 ugie_pkg::ENABLE_MASK_DEV)))
    else $error("enable write did not land");

  a_enable_reset_value: assert property (
    $rose(aresetn) |-> en == 8'h06)
    else $error("enable does not read 0x06 after reset");

  a_detach_gate: assert property (
    c_reg.host_mode && st[5] && en[5] |-> irq)
    else $error("enabled detach event not forwarded");

  a_attach_gate: assert property (
    c_reg.host_mode && st[4] && en[4] |-> irq)
    else $error("enabled attach event not forwarded");

  a_sof_suppressed: assert property (
    c_reg.host_mode && st[3] && !en[3] && ((st & en) == 8'h00) |-> !irq)
    else $error("disabled start of frame reached the interrupt");

  a_babble_gate: assert property (
    c_reg.host_mode && st[2] && en[2] |-> irq)
    else $error("enabled babble event not forwarded");

  a_host_enable_reserved: assert property (
    c_reg.host_mode |-> en[7:6] == 2'b00 && !en[0])
    else $error("reserved host enable bits are set");

  a_read_clears: assert property (
    rd_status && set_bits == 8'h00 && mode_still |=> st == 8'h00)
    else $error("status read did not clear the active bits");

  a_detach_sets_bit: assert property (
    c_reg.host_mode && mode_still && peer_detach_event |=> st[5])
    else $error("detach did not set bit 5");

  a_attach_sets_bit: assert property (
    c_reg.host_mode && mode_still && peer_attach_event |=> st[4])
    else $error("attach did not set bit 4");

  a_babble_waits_sof: assert property (
    c_reg.host_mode && mode_still && !st[2] && !c_reg.sof_sent |=> !st[2])
    else $error("babble reported before the first frame start");

  a_irq_is_or: assert property (
    ((st & en) != 8'h00) |-> irq ##1 (((st & en) == 8'h00) || irq))
    else $error("interrupt low with an enabled status bit set");

  a_set_beats_clear: assert property (
    rd_status && sof_event |=> st[3] ##1 (st[3] || $past(rd_status)))
    else $error("event lost in the cycle of a clearing read");

  a_read_returns_status: assert property (
    rd_status |=> s_axi_rdata[7:0] == $past(st))
    else $error("status read did not return the bits it cleared");

  a_status_write_refused: assert property (
    wr_status |=> s_axi_bresp == ugie_pkg::RESP_SLVERR)
    else $error("write to the read-only status was not refused");

  a_babble_after_sof: assert property (
    c_reg.host_mode && mode_still && c_reg.sof_sent && babble_event |=> st[2])
    else $error("babble after a frame start did not set bit 2");

  // a false interrupt right after reset would reach the processor before setup
  a_quiet_after_reset: assert property (
    $rose(aresetn) |-> !irq && st == 8'h00)
    else $error("interrupt or status not clear after reset");

  c_irq_raised: cover property ($rose(irq));
  c_mode_change: cover property ($changed(c_reg.host_mode));
  c_read_clear: cover property (rd_status && st != 8'h00 ##1 st == 8'h00);
  c_babble_set: cover property (c_reg.host_mode && $rose(st[2]));
  c_set_on_clear: cover property (rd_status && sof_event);

endmodule : ugie_general_irq

// ===== ugie_general_irq_bench.sv
// self-checking bench for the general event interrupt block
`timescale 1ns/1ps
module ugie_general_irq_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic [6:0] cmd = 7'h00;
  logic awready, wready, bvalid, arready, rvalid, irq, host_mode;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic sof_e, rst_e, res_e, sus_e, att_e, det_e, bab_e;
  int mismatches = 0, n_tests = 0, seed = 32'h0000_d24d;
  int ms, m_en, m_host, sus, sent, set, k;
  int q[$];
  bit wr_busy = 1'b0;
  localparam logic [6:0] HOST_EV [1:5] = '{7'h04, 7'h40, 7'h01, 7'h10, 7'h20};
  localparam logic [6:0] DEV_EV [0:3] = '{7'h08, 7'h04, 7'h02, 7'h01};

  ugie_general_irq #(.ADDR_W(8)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sof_event(sof_e), .bus_reset_event(rst_e), .resume_event(res_e),
    .suspend_event(sus_e), .peer_attach_event(att_e), .peer_detach_event(det_e),
    .babble_event(bab_e), .irq(irq), .host_mode(host_mode));
  ugie_bus_peer peer (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .sof_event(sof_e),
    .bus_reset_event(rst_e), .resume_event(res_e), .suspend_event(sus_e),
    .peer_attach_event(att_e), .peer_detach_event(det_e), .babble_event(bab_e));

  initial
  begin
    forever #2 aclk = ~aclk;
  end

  function automatic int msk();
    return m_host ? 32'h0000_003e : 32'h0000_000f;
  endfunction : msk

  //////////////////////////////////////////////////////////////////////////////
  // reference model, sampled on the same edge as the block
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ms = 0;
      m_en = 32'h0000_0006;
      m_host = 0;
      sus = 0;
      sent = 0;
    end
    else
    begin
      if (m_host)
        set = {det_e, att_e, sof_e, bab_e && sent != 0, res_e && sus != 0, 1'b0};
      else
        set = {sof_e, rst_e, res_e && sus != 0, sus_e};
      if (arvalid && arready && araddr == 8'h28)
      begin
        q.push_back(ms);
        ms = 0;
      end
      ms = ms | set;
      if (res_e || rst_e)
        sus = 0;
      if (sus_e)
        sus = 1;
      if (m_host && sof_e)
        sent = 1;
      if (m_host && rst_e)
        sent = 0;
    end
  end

  // irq and mode follow the model every cycle outside register writes
  always @(negedge aclk)
  begin
    if (aresetn && !wr_busy)
    begin
      cmp_bit(irq, (ms & m_en) != 0);
      cmp_bit(host_mode, m_host[0]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic hang();
    mismatches++;
    tally_and_finish();
  endtask : hang

  // one write; status and unmapped places must answer with an error
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    wr_busy = 1'b1;
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (n < 100 && bvalid !== 1'b1);
    if (n >= 100)
      hang();
    cmp_word({30'h0, bresp}, (a == 8'h2c || a == 8'h40) ? 0 : 2);
    // a write with lane 0 off is answered but changes nothing
    if (a == 8'h2c && wstrb[0])
      m_en = v & msk();
    if (a == 8'h40 && wstrb[0] && v[0] != m_host[0])
    begin
      m_host = v[0];
      sus = 0;
      sent = 0;
      ms = ms & msk();
      m_en = m_en & msk();
    end
    bready <= 1'b0;
    wr_busy = 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    logic [31:0] e;
    n = 0;
    e = a == 8'h2c ? m_en : (a == 8'h40 ? {sent[0], sus[0], m_host[0]} : 0);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (n < 100 && rvalid !== 1'b1);
    if (n >= 100 || (a == 8'h28 && q.size() == 0))
      hang();
    if (a == 8'h28)
      e = q.pop_front();
    cmp_word(rdata, e);
    cmp_word({30'h0, rresp}, (a == 8'h28 || a == 8'h2c || a == 8'h40) ? 0 : 2);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic ev(input logic [6:0] c);
    cmd <= c;
    @(posedge aclk);
    cmd <= 7'h00;
    repeat (2) @(posedge aclk);
  endtask : ev

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h28);
    rd(8'h2c);
    rd(8'h40);
    wr(8'h28, 8'hff);
    rd(8'h30);
    wr(8'h34, 8'h01);
    wr(8'h2c, 8'hff);
    rd(8'h2c);
    for (int i = 0; i < 7; i++)
      ev(7'h01 << i);
    ev(7'h04);
    rd(8'h28);
    rd(8'h28);
    // pulse lands on the same edge that takes the clearing read
    cmd <= 7'h01;
    @(posedge aclk);
    cmd <= 7'h00;
    rd(8'h28);
    rd(8'h28);
    for (int b = 0; b < 4; b++)
    begin
      wr(8'h2c, 8'h01 << b);
      ev(DEV_EV[b]);
      rd(8'h28);
    end
    wr(8'h40, 8'h01);
    rd(8'h40);
    wr(8'h2c, 8'hff);
    rd(8'h2c);
    ev(7'h40);
    rd(8'h28);
    for (int b = 5; b > 0; b--)
    begin
      wr(8'h2c, 8'h01 << b);
      if (b == 1)
        ev(7'h08);
      ev(HOST_EV[b]);
      rd(8'h28);
    end
    repeat (300)
    begin
      k = $random(seed);
      wstrb <= {3'h7, |k[22:20]};
      if (k[4:0] == 5'h00)
        wr(8'h40, k[12:5]);
      else if (k[4:2] == 3'h0)
        wr(8'h2c, k[15:8]);
      ev(7'h01 << (($unsigned(k) >> 16) % 7));
      if (k[5])
        rd(8'h28);
    end
    rd(8'h28);
    tally_and_finish();
  end
endmodule : ugie_general_irq_bench

// ===== ugie_pkg.sv
// constants and types shared by the general event interrupt block
package ugie_pkg;

  // register indexes; the byte address is four times the index
  localparam logic [5:0] IDX_STATUS = 6'h0a;
  localparam logic [5:0] IDX_ENABLE = 6'h0b;
  localparam logic [5:0] IDX_CTRL = 6'h10;

  // status bit positions, host and device layouts share 3 and 1
  localparam int BIT_DETACH = 5;
  localparam int BIT_ATTACH = 4;
  localparam int BIT_SOF = 3;
  localparam int BIT_BABBLE = 2;
  localparam int BIT_RESET = 2;
  localparam int BIT_RESUME = 1;
  localparam int BIT_SUSPEND = 0;

  // control register fields
  localparam int BIT_HOST_MODE = 0;
  localparam int BIT_SUSPENDED = 1;
  localparam int BIT_SOF_SENT = 2;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h06;
  localparam logic HOST_MODE_RESET = 1'b0;

  // implemented bits per mode; all others read as zero
  localparam logic [7:0] STATUS_MASK_HOST = 8'h3e;
  localparam logic [7:0] STATUS_MASK_DEV = 8'h0f;
  localparam logic [7:0] ENABLE_MASK_HOST = 8'h3e;
  localparam logic [7:0] ENABLE_MASK_DEV = 8'h0f;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] enable;
    logic host_mode;
    logic suspended;
    logic sof_sent;
    logic irq;
  } ugie_core_t;

endpackage : ugie_pkg
